// ### pmo_assertions.sv
/* Port assertions for the program memory overlay map.
   Bound into pmo_overlay_map; the strap is held still per access. */
`timescale 1ns/100ps
`include "pmo_defs.svh"
module pmo_assertions
(
	input wire logic         core_clk,          // Clock.
	input wire logic         reset_n,           // Reset.
	input wire logic         strap_pin,         // Strap.
	input wire logic [2:0]   wait_cfg,          // Waits.
	input pmo_pkg::pmo_req_t fetch_req,         // Fetch.
	input pmo_pkg::pmo_req_t data_req,          // Data.
	input wire logic         fetch_done,        // Done.
	input wire logic         data_done,         // Done.
	input wire logic         reserved_hit,      // Hole.
	input wire logic [1:0]   pm_overlay_select, // Select.
	input wire logic         boot_enable,       // Boot.
	input wire logic         pms_n,             // Strobe.
	input wire logic         ext_addr_top_bit,  // Bit 13.
	input wire logic [12:0]  ext_addr_low_bits  // Low bits.
);
	import pmo_pkg::*;
	logic [2:0] st_q;
	logic [3:0] lc_q;
	logic       pq_q;
	logic       lo;
	logic       hi;
	logic       fv;
	// Strap history and strobe low count; the strap needs four quiet edges.
	always_ff @(posedge core_clk)
	begin
		st_q <= {st_q[1:0], strap_pin};
		pq_q <= pms_n;
		lc_q <= pms_n ? 4'h0 : lc_q + 4'h1;
	end
	// Idle bus with a settled strap; fv is a lone fetch.
	assign lo = st_q == 3'h0 && !strap_pin && pms_n && pq_q;
	assign hi = st_q == 3'h7 && strap_pin && pms_n && pq_q;
	assign fv = fetch_req.valid && !data_req.valid;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	int_fetch_a: assert property (
		lo && fv && fetch_req.addr <= `PMO_INT_LAST
		|=> fetch_done && !reserved_hit && pms_n)
		else $error("on-chip fetch not done in one cycle");
	dual_ram_a: assert property (
		lo && fetch_req.valid && data_req.valid &&
		fetch_req.addr <= `PMO_INT_LAST && data_req.addr <= `PMO_INT_LAST
		|=> fetch_done && data_done)
		else $error("two on-chip accesses not done together");
	low_hole_a: assert property (
		lo && fv && fetch_req.addr inside {[`PMO_RSV_FIRST:`PMO_RSV_LAST]}
		|=> reserved_hit && pms_n)
		else $error("reserved range not flagged");
	ovl_route_a: assert property (
		lo && fv && fetch_req.addr[13] && pm_overlay_select inside
		{`PMO_OVL_ONE, `PMO_OVL_TWO} |=> !pms_n &&
		ext_addr_top_bit == $past(pm_overlay_select[1]) &&
		ext_addr_low_bits == $past(fetch_req.addr[12:0]))
		else $error("overlay address wrong");
	strap_hole_a: assert property (
		hi && fv && fetch_req.addr[13] |=> reserved_hit && pms_n)
		else $error("upper window not reserved with strap high");
	strap_ext_a: assert property (
		hi && fv && !fetch_req.addr[13] |=> !pms_n && !ext_addr_top_bit)
		else $error("low window not external with strap high");
	boot_gate_a: assert property (
		st_q == {3{strap_pin}} |=> boot_enable == !$past(strap_pin))
		else $error("boot enable does not follow strap");
	ext_len_a: assert property (
		$rose(pms_n) |-> lc_q == {1'b0, wait_cfg} + 4'h1)
		else $error("strobe length differs from wait count");
	ext_done_a: assert property (
		$rose(pms_n) |=> fetch_done || data_done)
		else $error("external access did not complete");
	cover property ($rose(pms_n));
	cover property (reserved_hit);
	cover property (fetch_done && data_done);
endmodule

bind pmo_overlay_map pmo_assertions i_chk (.core_clk, .reset_n, .strap_pin,
	.wait_cfg, .fetch_req, .data_req, .fetch_done, .data_done, .reserved_hit,
	.pm_overlay_select, .boot_enable, .pms_n, .ext_addr_top_bit,
	.ext_addr_low_bits);

// ### pmo_decode.sv
/*
 * Combinational decode of one 14-bit program address to a target.
 * Assumes the strap is already synchronised by the caller.
 */
`timescale 1ns/100ps
`include "pmo_defs.svh"

module pmo_decode
(
	input  wire logic [13:0]         addr,      // Program address.
	input  wire logic                strap,     // Mode strap, synchronised.
	input  wire logic [1:0]          ovl_sel,   // Overlay select value.
	output pmo_pkg::pmo_target_t     target     // Chosen target.
);
	import pmo_pkg::*;

	// Map depends on strap first, overlay select second.
	always_comb
	begin
		target = PMO_TGT_RSV;
		if (strap)
		begin
			// [R10] external low map
			if (addr <= `PMO_RSV_LAST)
				target = PMO_TGT_EXT;
		end
		else if (addr <= `PMO_INT_LAST)
			target = PMO_TGT_INT;
		// [R4] overlay window routing
		else if (addr >= `PMO_OVL_FIRST &&
			(ovl_sel == `PMO_OVL_ONE || ovl_sel == `PMO_OVL_TWO))
			target = PMO_TGT_EXT;
	end
endmodule

// ### pmo_defs.svh
/*
 * Constants for the program memory overlay map: address ranges, overlay
 * select encodings and wait timing. Assumes inclusion by bare name.
 */
`ifndef PMO_DEFS_SVH
`define PMO_DEFS_SVH

`define PMO_INT_LAST     14'h0FFF
`define PMO_RSV_FIRST    14'h1000
`define PMO_RSV_LAST     14'h1FFF
`define PMO_OVL_FIRST    14'h2000
`define PMO_OVL_LAST     14'h3FFF
`define PMO_OVL_NONE     2'h0
`define PMO_OVL_ONE      2'h1
`define PMO_OVL_TWO      2'h2
`define PMO_WAIT_RESET   3'h0
`define PMO_SEL_RESET    2'h0

`endif

// ### pmo_ext_mem.sv
/* External overlay memory on the program bus.
   Assumes the map drives select, address and write data. */
`timescale 1ns/100ps
module pmo_ext_mem
(
	input wire logic        core_clk,                  // Clock.
	input wire logic        pms_n,                     // Select, low.
	input wire logic        ext_we,                    // Write.
	input wire logic        ext_addr_top_bit,          // Bit 13.
	input wire logic [12:0] ext_addr_low_bits,         // Bits 12:0.
	input wire logic [23:0] ext_wdata,                 // Write word.
	output logic     [23:0] ext_rdata = 24'h000000     // Read word.
);
	logic [23:0] mem [0:16383];
	logic        hold_q;
	// Only selected accesses count.
	// Read data holds one cycle past deselect, then flips so stale reads fail.
	always_ff @(posedge core_clk)
	begin
		hold_q <= !pms_n;
		if (!pms_n && ext_we)
			mem[{ext_addr_top_bit, ext_addr_low_bits}] <= ext_wdata;
		if (!pms_n)
			ext_rdata <= mem[{ext_addr_top_bit, ext_addr_low_bits}];
		else if (!hold_q)
			ext_rdata <= ~ext_rdata;
	end
endmodule

// ### pmo_overlay_map.sv
/*
 * Program memory overlay map: decodes fetch and data addresses onto
 * on-chip RAM, a reserved hole or the external bus, and times external
 * accesses with wait states. Assumes a core that holds its request until
 * ready, and a strap pin that is asynchronous to core_clk.
 */
// What this block does
// [R1] Program space 24 bits, 4K words on-chip.
// [R2] On-chip RAM serves fetch and data together.
// [R3] Strap low: RAM low, 0x1000-0x1FFF reserved.
// [R4] Overlay 1 or 2 routes upper window external.
// [R5] Top address bit selects overlay; low 13 pass.
// [R6] Software avoids upper window with overlay zero.
// [R7] Sequencer loop tracking ignores overlay select.
// [R8] Overlay select not saved on interrupts.
// [R9] Strap high: no boot, overlay, or RAM.
// [R10] Strap high: external low 8K, upper reserved.
// [R11] Select strobe spans external access wait states.
`timescale 1ns/100ps
`include "pmo_defs.svh"

module pmo_overlay_map
#(
	parameter int DEPTH = 4096,                  // On-chip words.
	parameter int WIDTH = 24                     // Word width.
)
(
	input  wire logic                core_clk,     // Instruction clock.
	input  wire logic                reset_n,      // Sync reset, low.
	input  wire logic                strap_pin,    // Mode strap pin.
	input  wire logic                sel_wr,       // Load overlay select.
	input  wire logic [1:0]          sel_wdata,    // New overlay select.
	input  wire logic [2:0]          wait_cfg,     // External wait states.
	input  pmo_pkg::pmo_req_t        fetch_req,    // Instruction fetch.
	input  pmo_pkg::pmo_req_t        data_req,     // Data access.
	input  wire logic                data_we,      // Data is a write.
	input  wire logic [WIDTH-1:0]    data_wdata,   // Data write word.
	input  wire logic [WIDTH-1:0]    ext_rdata,    // External read bus.
	output logic [WIDTH-1:0]         fetch_word,   // Fetched word.
	output logic                     fetch_done,   // Fetch finished.
	output logic [WIDTH-1:0]         data_rword,   // Data read word.
	output logic                     data_done,    // Data finished.
	output logic                     reserved_hit, // Reserved access.
	output logic [1:0]               pm_overlay_select, // Select value.
	output logic                     boot_enable,  // Boot allowed.
	output logic                     pms_n,        // Program select.
	output logic                     ext_we,       // External write.
	output logic                     ext_addr_top_bit,  // Address bit 13.
	output logic [12:0]              ext_addr_low_bits, // Address 12:0.
	output logic [WIDTH-1:0]         ext_wdata     // External write bus.
);
	import pmo_pkg::*;

	typedef enum logic [2:0]
	{
		PMO_ST_IDLE = 3'h1,
		PMO_ST_WAIT = 3'h2,
		PMO_ST_DONE = 3'h4
	} pmo_state_t;

	logic              strap_meta_q;
	logic              strap_q;
	logic [WIDTH-1:0]  ram_q [DEPTH];
	pmo_target_t       fetch_tgt;
	pmo_target_t       data_tgt;
	pmo_state_t        state_q;
	logic [2:0]        wait_q;
	logic              ext_is_data_q;
	logic              fetch_ext;
	logic              data_ext;
	logic              ext_go;
	logic              ext_pick_data;
	logic [13:0]       ext_addr;

	// Strap is a pin: two flops before any decode looks at it.
	always_ff @(posedge core_clk)
	begin
		strap_meta_q <= strap_pin;
		strap_q      <= strap_meta_q;
	end

	pmo_decode u_fetch_dec
	(
		.addr    (fetch_req.addr),
		.strap   (strap_q),
		.ovl_sel (pm_overlay_select),
		.target  (fetch_tgt)
	);

	pmo_decode u_data_dec
	(
		.addr    (data_req.addr),
		.strap   (strap_q),
		.ovl_sel (pm_overlay_select),
		.target  (data_tgt)
	);

	// Overlay select register. It is plain state: nothing here pushes it
	// on an interrupt, and nothing feeds it to the loop logic.
	// [R7] not loop tracked
	// [R8] no stack save
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			pm_overlay_select <= `PMO_SEL_RESET;
		else if (sel_wr)
			pm_overlay_select <= sel_wdata;
	end

	// [R9] strap disables boot
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			boot_enable <= 1'b0;
		else
			boot_enable <= !strap_q;
	end

	// On-chip RAM: two independent ports, so a fetch and a data access
	// complete together. Strap high leaves the RAM unreachable because
	// the decode never yields an internal target then.
	// [R1] 4K by 24 storage
	// [R2] dual access per cycle
	always_ff @(posedge core_clk)
	begin
		if (data_req.valid && data_tgt == PMO_TGT_INT && data_we)
			ram_q[data_req.addr[11:0]] <= data_wdata;
	end

	// [R3] internal low range
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			fetch_word <= '0;
		else if (fetch_req.valid && fetch_tgt == PMO_TGT_INT)
			fetch_word <= ram_q[fetch_req.addr[11:0]];
		else if (state_q == PMO_ST_DONE && !ext_is_data_q)
			fetch_word <= ext_rdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			data_rword <= '0;
		else if (data_req.valid && data_tgt == PMO_TGT_INT)
			data_rword <= ram_q[data_req.addr[11:0]];
		else if (state_q == PMO_ST_DONE && ext_is_data_q)
			data_rword <= ext_rdata;
	end

	// Only one external access runs at a time; data has priority since
	// a stalled fetch simply retries after.
	assign fetch_ext     = fetch_req.valid && fetch_tgt == PMO_TGT_EXT;
	assign data_ext      = data_req.valid && data_tgt == PMO_TGT_EXT;
	assign ext_go        = state_q == PMO_ST_IDLE && (fetch_ext || data_ext);
	assign ext_pick_data = data_ext;
	assign ext_addr      = ext_pick_data ? data_req.addr : fetch_req.addr;

	// External access sequencer with wait-state countdown.
	// [R11] strobe over wait states
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			state_q       <= PMO_ST_IDLE;
			wait_q        <= `PMO_WAIT_RESET;
			ext_is_data_q <= 1'b0;
			pms_n         <= 1'b1;
		end
		else
		begin
			unique case (state_q)
				PMO_ST_IDLE:
				begin
					if (ext_go)
					begin
						state_q       <= PMO_ST_WAIT;
						wait_q        <= wait_cfg;
						ext_is_data_q <= ext_pick_data;
						pms_n         <= 1'b0;
					end
				end
				PMO_ST_WAIT:
				begin
					if (wait_q == 3'h0)
					begin
						state_q <= PMO_ST_DONE;
						pms_n   <= 1'b1;
					end
					else
						wait_q <= wait_q - 3'h1;
				end
				PMO_ST_DONE:
					state_q <= PMO_ST_IDLE;
				default:
					state_q <= PMO_ST_IDLE;
			endcase
		end
	end

	// External address and write data, latched at launch.
	// [R5] overlay top bit
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			ext_addr_top_bit  <= 1'b0;
			ext_addr_low_bits <= 13'h0000;
			ext_we            <= 1'b0;
			ext_wdata         <= '0;
		end
		else if (ext_go)
		begin
			// [R10] strap high keeps bit low
			ext_addr_top_bit  <= !strap_q &&
				pm_overlay_select == `PMO_OVL_TWO;
			ext_addr_low_bits <= ext_addr[12:0];
			ext_we            <= ext_pick_data && data_we;
			ext_wdata         <= data_wdata;
		end
		else if (state_q == PMO_ST_DONE)
			ext_we <= 1'b0;
	end

	// Completion pulses: internal at once, external after DONE.
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			fetch_done <= 1'b0;
			data_done  <= 1'b0;
		end
		else
		begin
			fetch_done <= (fetch_req.valid && fetch_tgt != PMO_TGT_EXT) ||
				(state_q == PMO_ST_DONE && !ext_is_data_q);
			data_done  <= (data_req.valid && data_tgt != PMO_TGT_EXT) ||
				(state_q == PMO_ST_DONE && ext_is_data_q);
		end
	end

	// Reserved hits are flagged; this includes the upper window with
	// overlay zero, which software must avoid.
	// [R6] flag forbidden window
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			reserved_hit <= 1'b0;
		else
			reserved_hit <= (fetch_req.valid && fetch_tgt == PMO_TGT_RSV) ||
				(data_req.valid && data_tgt == PMO_TGT_RSV);
	end
endmodule

// ### pmo_pkg.sv
/*
 * Types shared by the program memory overlay map.
 * Assumes pmo_defs.svh is compiled alongside.
 */
package pmo_pkg;

	// Kind of target chosen for one program address.
	typedef enum logic [2:0]
	{
		PMO_TGT_INT = 3'h1,
		PMO_TGT_EXT = 3'h2,
		PMO_TGT_RSV = 3'h4
	} pmo_target_t;

	// One core request on a program memory port.
	typedef struct packed
	{
		logic        valid;
		logic [13:0] addr;
	} pmo_req_t;

	// External bus address and select.
	typedef struct packed
	{
		logic        sel_n;
		logic        top_bit;
		logic [12:0] low_bits;
	} pmo_ext_t;

endpackage

// ### testbench.sv
/* Self-checking bench for the overlay map and its external memory.
   Assumes the memory model and the checker are compiled first. */
`timescale 1ns/100ps
`include "pmo_defs.svh"
module testbench;
	import pmo_pkg::*;
	logic core_clk = 1'b0, reset_n = 1'b0, strap_pin = 1'b0, sel_wr = 1'b0;
	logic [1:0] sel_wdata = 2'h0, pm_overlay_select;
	logic [2:0] wait_cfg = 3'h0;
	pmo_req_t fetch_req = 15'h0000, data_req = 15'h0000;
	logic data_we = 1'b0, fetch_done, data_done, reserved_hit, boot_enable;
	logic pms_n, ext_we, ext_addr_top_bit;
	logic [12:0] ext_addr_low_bits;
	logic [23:0] data_wdata = 24'h0, fetch_word, data_rword, ext_rdata;
	logic [23:0] ext_wdata;
	int error_cnt = 0, checks = 0;
	pmo_overlay_map i_dut (.core_clk, .reset_n, .strap_pin, .sel_wr,
		.sel_wdata, .wait_cfg, .fetch_req, .data_req, .data_we, .data_wdata,
		.ext_rdata, .fetch_word, .fetch_done, .data_rword, .data_done,
		.reserved_hit, .pm_overlay_select, .boot_enable, .pms_n, .ext_we,
		.ext_addr_top_bit, .ext_addr_low_bits, .ext_wdata);
	pmo_ext_mem i_mem (.core_clk, .pms_n, .ext_we, .ext_addr_top_bit,
		.ext_addr_low_bits, .ext_wdata, .ext_rdata);
	// A 100 ns clock.
	always #50 core_clk = ~core_clk;
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Reset for five edges; strobe and overlay select must come back idle.
	task automatic rst();
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		@(negedge core_clk);
		chk(24'({pms_n, pm_overlay_select}), 24'h4);
	endtask
	// One access; n extra edges cover the external strobe and finish state.
	task automatic acc(input bit d, input bit we, input logic [13:0] a,
		input logic [23:0] wd, input int n);
		@(posedge core_clk);
		if (d)
		begin
			data_req <= {1'b1, a};
			data_we <= we;
			data_wdata <= wd;
		end
		else
			fetch_req <= {1'b1, a};
		repeat (n + 1) @(posedge core_clk);
		data_req.valid <= 1'b0;
		fetch_req.valid <= 1'b0;
		@(negedge core_clk);
		chk(24'(d ? data_done : fetch_done), 24'h1);
	endtask
	// Overlay select and wait count change only while the bus is idle.
	task automatic set_ovl(input logic [1:0] v, input logic [2:0] w);
		@(posedge core_clk);
		sel_wr <= 1'b1;
		sel_wdata <= v;
		wait_cfg <= w;
		@(posedge core_clk);
		sel_wr <= 1'b0;
		@(negedge core_clk);
		chk(24'(pm_overlay_select), 24'(v));
	endtask
	// On-chip RAM: single fetch, dual read, then the hole above it.
	task automatic t_ram();
		acc(1, 1, 14'h0ABC, 24'h5A5A5A, 0);
		acc(0, 0, 14'h0ABC, 24'h0, 0);
		chk(fetch_word, 24'h5A5A5A);
		chk(24'(boot_enable), 24'h1);
		@(posedge core_clk);
		fetch_req <= {1'b1, 14'h0FFF};
		data_req <= {1'b1, 14'h0ABC};
		data_we <= 1'b0;
		@(posedge core_clk);
		fetch_req.valid <= 1'b0;
		data_req.valid <= 1'b0;
		@(negedge core_clk);
		chk(24'({fetch_done, data_done}), 24'h3);
		chk(data_rword, 24'h5A5A5A);
		acc(0, 0, 14'h1FFF, 24'h0, 0);
		chk(24'(reserved_hit), 24'h1);
	endtask
	// Overlay set before the upper window is touched.
	// Both overlays share low bits; only the top bit parts them.
	task automatic t_ovl();
		set_ovl(`PMO_OVL_ONE, 3'h2);
		acc(1, 1, 14'h2005, 24'h111111, 4);
		set_ovl(`PMO_OVL_TWO, 3'h0);
		acc(1, 1, 14'h2005, 24'h222222, 2);
		acc(0, 0, 14'h2005, 24'h0, 2);
		chk(fetch_word, 24'h222222);
		set_ovl(`PMO_OVL_ONE, 3'h7);
		acc(0, 0, 14'h2005, 24'h0, 9);
		chk(fetch_word, 24'h111111);
	endtask
	// Strap high: low 8K goes off chip, upper window is a hole.
	task automatic t_strap();
		@(posedge core_clk);
		strap_pin <= 1'b1;
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		chk(24'(boot_enable), 24'h0);
		acc(1, 1, 14'h0ABC, 24'h333333, 9);
		acc(0, 0, 14'h0ABC, 24'h0, 9);
		chk(fetch_word, 24'h333333);
		acc(1, 0, 14'h0ABC, 24'h0, 9);
		chk(data_rword, 24'h333333);
		acc(0, 0, 14'h2000, 24'h0, 0);
		chk(24'(reserved_hit), 24'h1);
	endtask
	// Cuts a hang short well past the expected run.
	initial
	begin
		repeat (2000) @(posedge core_clk);
		error_cnt++;
		print_verdict();
	end
	initial
	begin
		rst();
		t_ram();
		t_ovl();
		rst();
		t_strap();
		print_verdict();
	end
endmodule
